// *** sensor_regs_map.vh ***
// register offsets, field positions, reset values and timing counts
`ifndef SENSOR_REGS_MAP_VH
`define SENSOR_REGS_MAP_VH
`define OFS_RISE_RATE      8'h07
`define OFS_SERIAL_HIGH    8'h08
`define OFS_SERIAL_MID     8'h09
`define OFS_SERIAL_LOW     8'h0A
`define OFS_PART_ID        8'h0B
`define OFS_CONV_PERIOD    8'h0C
`define OFS_CRC_CTRL       8'h0D
`define RATE_MSB           14
`define RATE_LSB           2
`define RATE_RESET         13'h0140
`define REV_MSB            15
`define REV_LSB            12
`define CODE_MSB           11
`define CODE_LSB           0
`define CLK_PERIOD_NS      10
`define PERIOD_STEP_US     100
`define STEP_CYCLES        24'h002710
`define PERIOD_MIN_STEPS   16'h0040
`define PERIOD_MAX_STEPS   16'h4E20
`define PERIOD_RESET_STEPS 16'h09C4
`endif

// *** sensor_id_slew_register_bank.v ***
// upper register bank of the temperature sensor: rate limit, serial, id
//
// Operation
// - rate limit holds 13-bit unsigned in bits 14:2, resets to 0140h.
// - rate limit bit 15 and bits 1:0 always read zero.
// - offset 08h reads serial bits 47:32, read-only.
// - offset 09h reads serial bits 31:16, part-specific, no fixed reset.
// - offset 0Ah reads serial bits 15:0, fixed per part.
// - offset 0Bh bits 15:12 hold the 4-bit revision, read-only.
// - offset 0Bh bits 11:0 hold the 12-bit device-type code, read-only.
// - conversion every 250 ms by default, programmable 6.4 ms to 2 s.
// - optional CRC enable in offset 0Dh bit 0; no CRC is generated or checked here.
// - rate alert only when rising slew exceeds the limit.
`timescale 1ns/10ps
`include "sensor_regs_map.vh"
module sensor_id_slew_register_bank #(
  parameter [47:0] UNIQUE_SERIAL = 48'h0123_4567_89AB, // arbitrary value
  parameter [3:0]  REVISION      = 4'hA,               // arbitrary value
  parameter [11:0] DEVICE_CODE   = 12'h5A5,            // arbitrary value
  parameter [23:0] STEP_CYCLES   = `STEP_CYCLES
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  input  wire        slew_valid,
  input  wire [15:0] slew_rate,
  output reg         conv_start,
  output reg         crc_enable,
  output reg         rate_alert
);

// ----------------------------------------------------------------------
// writable registers and conversion timer state
// ----------------------------------------------------------------------
reg [12:0] rate_limit_reg;
reg [15:0] period_reg;
reg [23:0] step_cnt_reg;
reg [15:0] step_total_reg;
wire [15:0] period_clip;

// out-of-range period writes clamp so the timer never stalls or races
assign period_clip = (reg_wdata < `PERIOD_MIN_STEPS) ? `PERIOD_MIN_STEPS :
                     (reg_wdata > `PERIOD_MAX_STEPS) ? `PERIOD_MAX_STEPS :
                     reg_wdata;

always @(posedge clk or posedge rst) begin
  if (rst) begin
    rate_limit_reg <= `RATE_RESET;
    period_reg     <= `PERIOD_RESET_STEPS;
    crc_enable     <= 1'b0;
  end else if (reg_wr) begin
    case (reg_addr)
      `OFS_RISE_RATE: begin
        rate_limit_reg <= reg_wdata[`RATE_MSB:`RATE_LSB];
      end
      `OFS_CONV_PERIOD: begin
        period_reg <= period_clip;
      end
      `OFS_CRC_CTRL: begin
        crc_enable <= reg_wdata[0];
      end
      default: begin
        // serial and id offsets fall here and are ignored
      end
    endcase
  end
end

// ----------------------------------------------------------------------
// conversion timer
// ----------------------------------------------------------------------
always @(posedge clk or posedge rst) begin
  if (rst) begin
    step_cnt_reg   <= 24'h000000;
    step_total_reg <= 16'h0000;
    conv_start     <= 1'b0;
  end else begin
    conv_start <= 1'b0;
    if (step_cnt_reg >= STEP_CYCLES - 24'h000001) begin
      step_cnt_reg <= 24'h000000;
      if (step_total_reg >= period_reg - 16'h0001) begin
        step_total_reg <= 16'h0000;
        conv_start     <= 1'b1;
      end else begin
        step_total_reg <= step_total_reg + 16'h0001;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 24'h000001;
    end
  end
end

// ----------------------------------------------------------------------
// rate alert: slew_rate is signed, same scale as the limit
// ----------------------------------------------------------------------
always @(posedge clk or posedge rst) begin
  if (rst) begin
    rate_alert <= 1'b0;
  end else if (slew_valid) begin
    // negative slew has the sign bit set and never alerts
    rate_alert <= ~slew_rate[15] &&
                  (slew_rate[14:0] > {2'b00, rate_limit_reg});
  end
end

// ----------------------------------------------------------------------
// read mux
// ----------------------------------------------------------------------
always @(posedge clk or posedge rst) begin
  if (rst) begin
    reg_rdata <= 16'h0000;
  end else begin
    case (reg_addr)
      `OFS_RISE_RATE:   reg_rdata <= {1'b0, rate_limit_reg, 2'b00};
      `OFS_SERIAL_HIGH: reg_rdata <= UNIQUE_SERIAL[47:32];
      `OFS_SERIAL_MID:  reg_rdata <= UNIQUE_SERIAL[31:16];
      `OFS_SERIAL_LOW:  reg_rdata <= UNIQUE_SERIAL[15:0];
      `OFS_PART_ID:     reg_rdata <= {REVISION, DEVICE_CODE};
      // revision and code share one word
      `OFS_CONV_PERIOD: reg_rdata <= period_reg;
      `OFS_CRC_CTRL:    reg_rdata <= {15'h0000, crc_enable};
      default:          reg_rdata <= 16'h0000;
    endcase
  end
end

endmodule // sensor_id_slew_register_bank

// *** bank_props_properties.sv ***
// assertion checker for the sensor register bank
`timescale 1ns/10ps
module bank_props #(parameter [47:0] UNIQUE_SERIAL = 48'h0,
  parameter [3:0] REVISION = 4'h0, parameter [11:0] DEVICE_CODE = 12'h0) (
  input wire clk, rst, reg_wr, slew_valid, conv_start, crc_enable,
  input wire rate_alert, input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata, reg_rdata, slew_rate);
  reg [7:0] pa_reg; // read data answers the address of one edge before
  always @(posedge clk) pa_reg <= reg_addr;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rsvd_zero: assert property (pa_reg == 8'h07 |->
    !reg_rdata[15] && reg_rdata[1:0] == 2'h0) else $error("reserved bits");
  a_serial_high: assert property (pa_reg == 8'h08 |->
    reg_rdata == UNIQUE_SERIAL[47:32]) else $error("serial high");
  a_serial_mid: assert property (pa_reg == 8'h09 |->
    reg_rdata == UNIQUE_SERIAL[31:16]) else $error("serial mid");
  a_serial_low: assert property (pa_reg == 8'h0A |->
    reg_rdata == UNIQUE_SERIAL[15:0]) else $error("serial low");
  a_id_rev: assert property (pa_reg == 8'h0B |->
    reg_rdata[15:12] == REVISION) else $error("revision");
  a_id_code: assert property (pa_reg == 8'h0B |->
    reg_rdata[11:0] == DEVICE_CODE) else $error("device code");
  a_alert_neg: assert property ($past(slew_valid) &&
    $past(slew_rate[15]) |-> !rate_alert) else $error("falling alert");
  a_alert_hold: assert property (!$past(slew_valid) |->
    $stable(rate_alert)) else $error("alert moved");
endmodule // bank_props
bind sensor_id_slew_register_bank bank_props #(.UNIQUE_SERIAL(UNIQUE_SERIAL),
  .REVISION(REVISION), .DEVICE_CODE(DEVICE_CODE)) u_props (.*);

// *** host_model.sv ***
// register bus host model
`timescale 1ns/10ps
module host_model (input wire clk, input wire [15:0] reg_rdata,
  output reg [7:0] reg_addr = 8'hFF, output reg reg_wr = 1'b0,
  output reg [15:0] reg_wdata = 16'h0);
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk) {reg_addr, reg_wr, reg_wdata} <= {a, 1'b1, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [15:0] d);
    @(posedge clk) reg_addr <= a;
    @(posedge clk) #1 d = reg_rdata;
  endtask
endmodule // host_model

// *** testbench.sv ***
// self-checking bench for the sensor register bank
`timescale 1ns/10ps
module testbench;
  localparam [47:0] SER = 48'hA1B2_C3D4_E5F6; // arbitrary value
  reg clk = 0, rst = 1, slew_valid = 0;
  reg [15:0] slew_rate = 16'h0, d;
  wire [15:0] reg_rdata, reg_wdata;
  wire [7:0] reg_addr;
  wire reg_wr, conv_start, crc_enable, rate_alert;
  integer error_cnt = 0, compares = 0, cyc = 0, t;
  initial forever #5 clk = ~clk;
  // a short step keeps the period test to a few hundred cycles
  sensor_id_slew_register_bank #(.UNIQUE_SERIAL(SER), .REVISION(4'h3),
    .DEVICE_CODE(12'h2C7), .STEP_CYCLES(24'h4)) u_dut (.*);
  host_model u_host (.*);
  task give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 25000) begin
    error_cnt++;
    give_verdict;
  end
  task chk(input string n, input [15:0] e, input [15:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task rc(input [7:0] a, input [15:0] e);
    u_host.rd(a, d);
    chk("rdata", e, d);
  endtask
  task sl(input [15:0] r, input e);
    @(posedge clk) {slew_valid, slew_rate} <= {1'b1, r};
    @(posedge clk) slew_valid <= 1'b0;
    #1 chk("alert", {15'h0, e}, {15'h0, rate_alert});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(8'h07, 16'h0500);
    u_host.wr(8'h07, 16'hFFFF);
    rc(8'h07, 16'h7FFC);
    for (t = 8; t < 12; t++) u_host.wr(8'(t), 16'hFFFF);
    rc(8'h08, SER[47:32]);
    rc(8'h09, SER[31:16]);
    rc(8'h0A, SER[15:0]);
    rc(8'h0B, 16'h32C7);
    rc(8'h07, 16'h7FFC);
    rc(8'hFF, 16'h0000);
    u_host.wr(8'h0D, 16'h0001);
    #1 chk("crc", 16'h0001, {15'h0, crc_enable});
    u_host.wr(8'h07, 16'h0500);
    sl(16'h0141, 1'b1);
    sl(16'h8141, 1'b0);
    sl(16'h0140, 1'b0);
    // below the minimum, so the period clamps to 64 steps
    u_host.wr(8'h0C, 16'h0001);
    rc(8'h0C, 16'h0040);
    rc(8'h0D, 16'h0001);
    @(posedge conv_start);
    @(posedge conv_start);
    t = cyc;
    @(posedge conv_start);
    chk("period", 16'd256, 16'(cyc - t));
    give_verdict;
  end
endmodule // testbench
